// File: logic/ubr_bank.v
// USB register bank with event flags, two interrupt vectors and low-power behaviour
`timescale 1ns/1ps
`include "ubr_defs.vh"
module ubr_bank (
  input wire clk_i,
  input wire sys_rst_i,
  input wire cpu_sel_i,
  input wire cpu_wr_i,
  input wire [6:0] cpu_addr_i,
  input wire [7:0] cpu_wdata_i,
  output reg [7:0] cpu_rdata_o,
  input wire cop_sel_i,
  input wire cop_wr_i,
  input wire [6:0] cop_addr_i,
  input wire [7:0] cop_wdata_i,
  output reg [7:0] cop_rdata_o,
  output reg cop_busy_o,
  input wire irq_mask_low_i,
  input wire irq_mask_high_i,
  input wire halt_i,
  input wire line_activity_i,
  input wire frame_start_i,
  input wire [10:0] frame_number_i,
  input wire bus_reset_i,
  input wire resume_i,
  input wire suspend_i,
  input wire packet_received_i,
  input wire packet_sent_i,
  input wire stall_sent_i,
  input wire setup_end_i,
  input wire [1:0] in_ep_done_i,
  input wire [1:0] out_ep_done_i,
  input wire [12:0] out_byte_count_i,
  output reg usb_irq_o,
  output reg suspend_end_irq_o,
  output reg wake_o,
  output reg high_speed_o,
  output reg [6:0] function_address_o
);
  reg [7:0] power_control;
  reg [7:0] function_address;
  reg [7:0] in_endpoint_event_flags;
  reg [7:0] out_endpoint_event_flags;
  reg [7:0] in_endpoint_event_enable;
  reg [7:0] out_endpoint_event_enable;
  reg [7:0] bus_event_enable;
  reg [7:0] bus_event_flags;
  reg [7:0] test_mode_control;
  reg [7:0] endpoint_select;
  reg [7:0] suspend_end_status;
  reg [7:0] suspend_end_control;
  reg [10:0] frame_number;
  reg [12:0] out_byte_count;
  reg [1:0] line_meta;
  reg line_sync;
  reg line_prev;
  reg [7:0] next_rdata;
  reg [7:0] next_cop_rdata;
  wire [7:0] ep_rdata;
  wire [7:0] ep_cop_rdata;
  wire cpu_go;
  wire cop_go;
  wire wr_go;
  wire [6:0] wr_addr;
  wire [7:0] wr_data;
  wire frozen;
  wire masked;
  wire ep0_evt;
  wire line_rise;
  wire any_bus_req;
  wire send_req;
  wire [3:0] ep_field;

  // Decode of a byte address against the bank, used for both masters
  function [7:0] read_reg;
    input [6:0] a;
    input [7:0] ep;
    begin
      case (a)
        `UBR_PWR: read_reg = power_control;
        `UBR_FUNCTION_ADDRESS: read_reg = function_address;
        `UBR_INFLG: read_reg = in_endpoint_event_flags;
        `UBR_OUTFLG: read_reg = out_endpoint_event_flags;
        `UBR_INEN: read_reg = in_endpoint_event_enable;
        `UBR_OUTEN: read_reg = out_endpoint_event_enable;
        `UBR_BUSEN: read_reg = bus_event_enable;
        `UBR_BUSFLG: read_reg = bus_event_flags;
        `UBR_FRMH: read_reg = {5'b00000, frame_number[10:8]};
        `UBR_FRML: read_reg = frame_number[7:0];
        `UBR_TEST: read_reg = test_mode_control;
        `UBR_EPSEL: read_reg = endpoint_select;
        `UBR_INMAXH, `UBR_INMAXL, `UBR_INCSH, `UBR_INCSL,
        `UBR_OUTMAXH, `UBR_OUTMAXL, `UBR_OUTCSH, `UBR_OUTCSL: read_reg = ep;
        `UBR_OUTCNTH: read_reg = {3'b000, out_byte_count[12:8]};
        `UBR_OUTCNTL: read_reg = out_byte_count[7:0];
        `UBR_SEND_ST: read_reg = suspend_end_status;
        `UBR_SEND_CT: read_reg = suspend_end_control;
        default: read_reg = `UBR_ZERO;
      endcase
    end
  endfunction

  // Write-one-to-clear: each 1 in the written byte drops the matching flag
  function [7:0] w1c;
    input [7:0] flags;
    input [7:0] data;
    begin
      w1c = flags & ~data;
    end
  endfunction

  // A flag asks for the common vector only while its enable is set
  function vec_req;
    input [7:0] flags;
    input [7:0] enables;
    begin
      vec_req = |(flags & enables);
    end
  endfunction

  // The window of byte addresses that the endpoint select steers
  function ep_window;
    input [6:0] a;
    begin
      ep_window = (a >= `UBR_INMAXH) && (a <= `UBR_OUTCSL);
    end
  endfunction

  // Halt freezes the bank except the suspend-end status bit; the coprocessor is refused while the CPU owns the cycle
  assign frozen = halt_i;
  assign cpu_go = cpu_sel_i && !frozen;
  assign cop_go = cop_sel_i && !frozen && !cpu_sel_i;
  assign wr_go = (cpu_go && cpu_wr_i) || (cop_go && cop_wr_i);
  assign wr_addr = cpu_go ? cpu_addr_i : cop_addr_i;
  assign wr_data = cpu_go ? cpu_wdata_i : cop_wdata_i;
  assign masked = irq_mask_low_i || irq_mask_high_i;
  assign ep0_evt = packet_received_i || packet_sent_i || stall_sent_i || setup_end_i;
  assign line_rise = line_sync && !line_prev;
  assign any_bus_req = vec_req(bus_event_flags, bus_event_enable)
    || vec_req(in_endpoint_event_flags, in_endpoint_event_enable)
    || vec_req(out_endpoint_event_flags, out_endpoint_event_enable);
  assign send_req = suspend_end_status[`UBR_SEND_BIT] && suspend_end_control[`UBR_SEND_BIT];

  // Bridge accesses steer the endpoint field only when the CPU leaves the cycle free
  assign ep_field = cpu_sel_i ? cpu_addr_i[3:0] : cop_addr_i[3:0];

  // Endpoint-indexed registers; fields 0..3 IN, 4..7 OUT, eight bytes per endpoint
  ubr_ep_regs #(
    .NUM_EP(3)
  ) i_ubr_ep_regs (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sel_i(endpoint_select[1:0]),
    .field_i(ep_field),
    .wr_i(wr_go && ep_window(wr_addr)),
    .wdata_i(wr_data),
    .hw_set_i(8'h00),
    .hw_ep_i(2'b00),
    .rdata_o(ep_rdata)
  );
  assign ep_cop_rdata = ep_rdata;

  // Live bus counters are sampled into the bank so that a halt freezes what reads return
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      frame_number <= 11'h000;
      out_byte_count <= 13'h0000;
    end else if (!frozen) begin
      frame_number <= frame_number_i;
      out_byte_count <= out_byte_count_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      line_meta <= 2'b00;
      line_sync <= 1'b0;
      line_prev <= 1'b0;
    end else begin
      line_meta <= {line_meta[0], line_activity_i};
      line_sync <= line_meta[1];
      line_prev <= line_sync;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      power_control <= `UBR_PWR_RST;
      function_address <= `UBR_ZERO;
      in_endpoint_event_flags <= `UBR_ZERO;
      out_endpoint_event_flags <= `UBR_ZERO;
      in_endpoint_event_enable <= `UBR_INEN_RST;
      out_endpoint_event_enable <= `UBR_OUTEN_RST;
      bus_event_enable <= `UBR_BUSEN_RST;
      bus_event_flags <= `UBR_ZERO;
      test_mode_control <= `UBR_ZERO;
      endpoint_select <= `UBR_ZERO;
      suspend_end_status <= `UBR_ZERO;
      suspend_end_control <= `UBR_ZERO;
    end else if (frozen) begin
      // Only the suspend-end path stays alive so line activity can end the halt
      if (line_rise && power_control[1]) begin
        suspend_end_status[`UBR_SEND_BIT] <= 1'b1;
      end
    end else begin
      // Writes first; hardware sets below override a same-cycle clear
      if (wr_go) begin
        case (wr_addr)
          `UBR_PWR: power_control <= wr_data & `UBR_PWR_MASK;
          `UBR_FUNCTION_ADDRESS: function_address <= wr_data;
          `UBR_INFLG: in_endpoint_event_flags <= w1c(in_endpoint_event_flags, wr_data);
          `UBR_OUTFLG: out_endpoint_event_flags <= w1c(out_endpoint_event_flags, wr_data);
          `UBR_INEN: in_endpoint_event_enable <= wr_data & `UBR_INEN_MASK;
          `UBR_OUTEN: out_endpoint_event_enable <= wr_data & `UBR_OUTEN_MASK;
          `UBR_BUSEN: bus_event_enable <= wr_data & `UBR_BUS_MASK;
          `UBR_BUSFLG: bus_event_flags <= w1c(bus_event_flags, wr_data);
          `UBR_TEST: test_mode_control <= wr_data & `UBR_TEST_MASK;
          `UBR_EPSEL: endpoint_select <= wr_data & `UBR_EPSEL_MASK;
          `UBR_SEND_ST: suspend_end_status <= w1c(suspend_end_status, wr_data & `UBR_SEND_CLR);
          `UBR_SEND_CT: suspend_end_control <= wr_data & `UBR_CTL_MASK;
          default: ;
        endcase
      end
      // Events keep latching in wait mode; wait does not gate this path
      if (frame_start_i) begin
        bus_event_flags[3] <= 1'b1;
      end
      if (bus_reset_i) begin
        bus_event_flags[2] <= 1'b1;
      end
      if (resume_i) begin
        bus_event_flags[1] <= 1'b1;
      end
      if (suspend_i) begin
        bus_event_flags[0] <= 1'b1;
        power_control[1] <= 1'b1;
      end
      if (ep0_evt) begin
        in_endpoint_event_flags[`UBR_EP0_BIT] <= 1'b1;
      end
      if (in_ep_done_i[0]) begin
        in_endpoint_event_flags[1] <= 1'b1;
      end
      if (in_ep_done_i[1]) begin
        in_endpoint_event_flags[2] <= 1'b1;
      end
      if (out_ep_done_i[0]) begin
        out_endpoint_event_flags[1] <= 1'b1;
      end
      if (out_ep_done_i[1]) begin
        out_endpoint_event_flags[2] <= 1'b1;
      end
      if (line_rise && power_control[1]) begin
        suspend_end_status[`UBR_SEND_BIT] <= 1'b1;
        power_control[1] <= 1'b0;
      end
    end
  end

  always @* begin
    next_rdata = read_reg(cpu_addr_i, ep_rdata);
    next_cop_rdata = read_reg(cop_addr_i, ep_cop_rdata);
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_rdata_o <= `UBR_ZERO;
      cop_rdata_o <= `UBR_ZERO;
      cop_busy_o <= 1'b0;
      usb_irq_o <= 1'b0;
      suspend_end_irq_o <= 1'b0;
      wake_o <= 1'b0;
      high_speed_o <= 1'b1;
      function_address_o <= 7'h00;
    end else begin
      // Reads return the stored value even in halt, where only the suspend-end status bit can change
      if (cpu_sel_i) begin
        cpu_rdata_o <= next_rdata;
      end
      if (cop_sel_i && !cpu_sel_i) begin
        cop_rdata_o <= next_cop_rdata;
      end
      cop_busy_o <= cop_sel_i && cpu_sel_i;
      usb_irq_o <= any_bus_req && !masked;
      suspend_end_irq_o <= send_req && !masked;
      // Only the suspend-end vector may leave halt; every enabled event leaves wait
      wake_o <= halt_i ? send_req : (any_bus_req || send_req);
      high_speed_o <= power_control[`UBR_HS_BIT];
      function_address_o <= function_address[6:0];
    end
  end
endmodule

// File: logic/ubr_defs.vh
// Register offsets, reset values and field positions of the USB register bank
`ifndef UBR_DEFS_VH
`define UBR_DEFS_VH
`define UBR_ADDR_W 7
`define UBR_PWR 7'h00
`define UBR_FUNCTION_ADDRESS 7'h01
`define UBR_INFLG 7'h03
`define UBR_OUTFLG 7'h05
`define UBR_INEN 7'h07
`define UBR_OUTEN 7'h09
`define UBR_BUSEN 7'h0A
`define UBR_BUSFLG 7'h0B
`define UBR_FRMH 7'h0C
`define UBR_FRML 7'h0D
`define UBR_TEST 7'h0E
`define UBR_EPSEL 7'h0F
`define UBR_INMAXH 7'h10
`define UBR_INMAXL 7'h11
`define UBR_INCSH 7'h12
`define UBR_INCSL 7'h13
`define UBR_OUTMAXH 7'h14
`define UBR_OUTMAXL 7'h15
`define UBR_OUTCSH 7'h16
`define UBR_OUTCSL 7'h17
`define UBR_OUTCNTH 7'h18
`define UBR_OUTCNTL 7'h19
`define UBR_SEND_ST 7'h5F
`define UBR_SEND_CT 7'h60
`define UBR_PWR_RST 8'h20
`define UBR_INEN_RST 8'h07
`define UBR_OUTEN_RST 8'h06
`define UBR_BUSEN_RST 8'h06
`define UBR_ZERO 8'h00
`define UBR_BUS_MASK 8'h0F
`define UBR_INEN_MASK 8'h07
`define UBR_OUTEN_MASK 8'h06
`define UBR_EPSEL_MASK 8'h03
`define UBR_MAXH_MASK 8'h07
`define UBR_PWR_MASK 8'h7F
`define UBR_CTL_MASK 8'h81
`define UBR_TEST_MASK 8'h3F
`define UBR_SEND_CLR 8'h01
`define UBR_HS_BIT 5
`define UBR_EP0_BIT 0
`define UBR_SEND_BIT 0
`endif

// File: logic/ubr_ep_regs.v
// Per-endpoint max packet and control/status storage selected by index
`timescale 1ns/1ps
module ubr_ep_regs #(
  parameter NUM_EP = 3
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [1:0] sel_i,
  input wire [3:0] field_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] hw_set_i,
  input wire [1:0] hw_ep_i,
  output wire [7:0] rdata_o
);
  // Eight bytes per endpoint so the IN and OUT halves never alias
  reg [7:0] mem [0:NUM_EP*8-1];
  integer k;
  wire [4:0] idx;
  wire [4:0] hw_idx;
  assign idx = {sel_i, field_i[2:0]};
  assign hw_idx = {hw_ep_i, 3'b011};
  assign rdata_o = (sel_i < NUM_EP) ? mem[idx] : 8'h00;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (k = 0; k < NUM_EP*8; k = k + 1) begin
        mem[k] <= 8'h00;
      end
    end else begin
      if (wr_i && sel_i < NUM_EP) begin
        mem[idx] <= wdata_i;
      end
      // Hardware status bits win over a software write in the same cycle
      if (hw_ep_i < NUM_EP && |hw_set_i) begin
        mem[hw_idx] <= mem[hw_idx] | hw_set_i | ((wr_i && idx == hw_idx) ? wdata_i : 8'h00);
      end
    end
  end
endmodule

// File: tb/ubr_bank_sva.sv
// Port-level checks for the USB register bank
`timescale 1ns/1ps
`include "ubr_defs.vh"
module ubr_bank_sva (
  input wire clk_i,
  input wire sys_rst_i,
  input wire cpu_sel_i,
  input wire cpu_wr_i,
  input wire [6:0] cpu_addr_i,
  input wire [7:0] cpu_wdata_i,
  input wire [7:0] cpu_rdata_o,
  input wire cop_sel_i,
  input wire cop_busy_o,
  input wire irq_mask_low_i,
  input wire irq_mask_high_i,
  input wire halt_i,
  input wire bus_reset_i,
  input wire usb_irq_o,
  input wire suspend_end_irq_o,
  input wire high_speed_o,
  input wire [6:0] function_address_o
);
  wire msk = irq_mask_low_i | irq_mask_high_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  reset_outs_a: assert property ($fell(sys_rst_i) |-> high_speed_o && !usb_irq_o && !suspend_end_irq_o)
    else $error("outputs wrong after reset");
  mask_block_a: assert property (msk [*2] |-> !usb_irq_o && !suspend_end_irq_o)
    else $error("request raised while masked");
  irq_latency_a: assert property (bus_reset_i && !halt_i ##1 !msk && !halt_i |=> usb_irq_o)
    else $error("bus reset gave no common request");
  irq_hold_a: assert property (usb_irq_o && !$past(cpu_sel_i) && !$past(cop_sel_i) && !msk |=> usb_irq_o)
    else $error("common request dropped without a clear");
  halt_freeze_a: assert property (halt_i [*3] |-> $stable(function_address_o) && $stable(high_speed_o))
    else $error("register copy moved in halt");
  addr_copy_a: assert property (cpu_sel_i && cpu_wr_i && !halt_i && cpu_addr_i == `UBR_FUNCTION_ADDRESS |->
    ##2 function_address_o == $past(cpu_wdata_i[6:0], 2))
    else $error("address copy not updated");
  bridge_busy_a: assert property (cop_sel_i && cpu_sel_i && !halt_i |=> cop_busy_o)
    else $error("bridge not refused");
  enable_resv_a: assert property (cpu_sel_i && !cpu_wr_i && !halt_i && cpu_addr_i == `UBR_INEN |=>
    cpu_rdata_o[7:3] == 5'h00)
    else $error("reserved enable bits set");
endmodule

// File: tb/ubr_host_model.sv
// Event source standing in for the USB host and the bus line
`timescale 1ns/1ps
module ubr_host_model (
  input wire clk_i,
  input wire go_i,
  input wire [3:0] kind_i,
  output reg [12:0] ev_o
);
  initial ev_o = 13'h0000;
  // One-cycle pulses only, since the bank sets its flag again on every high cycle
  always @(posedge clk_i) begin
    ev_o <= go_i ? 13'h0001 << kind_i : 13'h0000;
  end
endmodule

// File: tb/test_ubr_bank.sv
// Self-checking bench for the USB register bank
`timescale 1ns/1ps
`include "ubr_defs.vh"
module test_ubr_bank;
  reg clk_i = 0, sys_rst_i = 1, cs = 0, cw = 0, os = 0, ow = 0, ml = 0, mh = 0, hlt = 0, go = 0;
  reg [6:0] ca = 0, oa = 0;
  reg [7:0] cd = 0, od = 0, rd_v, v;
  reg [3:0] kind = 0;
  reg [10:0] fn = 0;
  reg [14:0] f;
  wire [7:0] crd, ord;
  wire busy, uirq, eirq, wake, hs;
  wire [6:0] fad;
  wire [12:0] ev;
  integer n_mismatch = 0, checked = 0, i, m;
  localparam [134:0] rst_tab = {7'h00, 8'h20, 7'h07, 8'h07, 7'h09, 8'h06, 7'h0A, 8'h06, 7'h03, 8'h00,
    7'h05, 8'h00, 7'h0B, 8'h00, 7'h5F, 8'h00, 7'h60, 8'h00};
  ubr_bank i_ubr_bank (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cpu_sel_i(cs), .cpu_wr_i(cw), .cpu_addr_i(ca),
    .cpu_wdata_i(cd), .cpu_rdata_o(crd), .cop_sel_i(os), .cop_wr_i(ow), .cop_addr_i(oa), .cop_wdata_i(od),
    .cop_rdata_o(ord), .cop_busy_o(busy), .irq_mask_low_i(ml), .irq_mask_high_i(mh), .halt_i(hlt),
    .line_activity_i(ev[12]), .frame_start_i(ev[0]), .frame_number_i(fn), .bus_reset_i(ev[1]),
    .resume_i(ev[2]), .suspend_i(ev[3]), .packet_received_i(ev[4]), .packet_sent_i(ev[5]),
    .stall_sent_i(ev[6]), .setup_end_i(ev[7]), .in_ep_done_i(ev[9:8]), .out_ep_done_i(ev[11:10]),
    .out_byte_count_i({fn, 2'b01}), .usb_irq_o(uirq), .suspend_end_irq_o(eirq), .wake_o(wake),
    .high_speed_o(hs), .function_address_o(fad));
  ubr_host_model i_ubr_host_model (.clk_i(clk_i), .go_i(go), .kind_i(kind), .ev_o(ev));
  initial forever #5 clk_i = ~clk_i;
  function [14:0] flag_of(input [3:0] k);
    flag_of = k < 4 ? {`UBR_BUSFLG, 8'h08 >> k} : k < 8 ? {`UBR_INFLG, 8'h01} :
      k < 10 ? {`UBR_INFLG, 8'h01 << (k - 7)} : {`UBR_OUTFLG, 8'h01 << (k - 9)};
  endfunction
  task acc(input reg cop, input reg w, input reg [6:0] a, input reg [7:0] d);
    begin
      @(posedge clk_i);
      cs <= !cop; os <= cop; cw <= w; ow <= w; ca <= a; oa <= a; cd <= d; od <= d;
      @(posedge clk_i);
      cs <= 0; os <= 0;
      #1 rd_v = cop ? ord : crd;
    end
  endtask
  task cmp(input reg [7:0] g, input reg [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task pulse(input reg [3:0] k);
    begin
      @(posedge clk_i);
      kind <= k; go <= 1;
      @(posedge clk_i);
      go <= 0;
      repeat (3) @(posedge clk_i);
      #1;
    end
  endtask
  task print_verdict;
    begin
      $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    m = $urandom(43);
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 0;
    for (i = 0; i < 9; i = i + 1) begin
      acc(i[0], 0, rst_tab[(8 - i) * 15 + 8 +: 7], 8'h00);
      cmp(rd_v, rst_tab[(8 - i) * 15 +: 8]);
    end
    cmp(hs, 1);
    @(posedge clk_i);
    cs <= 1; os <= 1; cw <= 0; ow <= 1; ca <= `UBR_INEN; oa <= `UBR_FUNCTION_ADDRESS; od <= 8'h33;
    @(posedge clk_i);
    cs <= 0; os <= 0;
    #1 cmp(busy, 1);
    acc(1, 1, 7'h02, 8'hA5);
    cmp(fad, 0);
    acc(1, 0, 7'h02, 8'h00);
    cmp(rd_v, 8'h00);
    v = $urandom & 8'h7F;
    acc(0, 1, `UBR_FUNCTION_ADDRESS, v);
    acc(1, 0, `UBR_FUNCTION_ADDRESS, 8'h00);
    cmp(rd_v, v);
    acc(0, 1, `UBR_BUSEN, 8'h0F);
    for (i = 0; i < 12; i = i + 1) begin
      m = i == 1 ? 0 : $urandom % 4;
      f = flag_of(i);
      @(posedge clk_i);
      {mh, ml} <= m; fn <= $urandom;
      pulse(i);
      cmp(uirq, m == 0);
      cmp(wake, 1);
      acc(i[0], 0, f[14:8], 8'h00);
      cmp(rd_v & f[7:0], f[7:0]);
      acc(0, 1, f[14:8], f[7:0]);
      @(posedge clk_i);
      #1 cmp(uirq, 0);
    end
    {mh, ml} <= 0;
    acc(1, 0, `UBR_FRML, 8'h00);
    cmp(rd_v, fn[7:0]);
    acc(0, 1, `UBR_SEND_CT, 8'h01);
    @(posedge clk_i);
    hlt <= 1;
    acc(0, 1, `UBR_FUNCTION_ADDRESS, 8'h55);
    pulse(1);
    cmp(wake, 0);
    cmp(fad, v[6:0]);
    pulse(12);
    i = 0;
    while (wake !== 1'b1 && i < 20) begin
      @(posedge clk_i);
      #1 i = i + 1;
    end
    cmp(wake, 1);
    @(posedge clk_i);
    #1 cmp(eirq, 1);
    hlt <= 0;
    acc(1, 0, `UBR_SEND_ST, 8'h00);
    cmp(rd_v[0], 1);
    acc(0, 1, `UBR_SEND_ST, 8'h01);
    @(posedge clk_i);
    #1 cmp(eirq, 0);
    for (i = 1; i < 3; i = i + 1) begin
      acc(0, 1, `UBR_EPSEL, i);
      acc(0, 1, `UBR_INCSL, 8'h10);
      acc(0, 1, `UBR_OUTCSL, 8'h20);
      acc(0, 0, `UBR_INCSL, 8'h00);
      cmp(rd_v, 8'h10);
      acc(1, 0, `UBR_OUTCSL, 8'h00);
      cmp(rd_v, 8'h20);
    end
    print_verdict;
  end
endmodule
bind ubr_bank ubr_bank_sva i_ubr_bank_sva (.clk_i, .sys_rst_i, .cpu_sel_i, .cpu_wr_i, .cpu_addr_i, .cpu_wdata_i,
  .cpu_rdata_o, .cop_sel_i, .cop_busy_o, .irq_mask_low_i, .irq_mask_high_i, .halt_i, .bus_reset_i, .usb_irq_o,
  .suspend_end_irq_o, .high_speed_o, .function_address_o);
